// >>> core/timer16_dual_slope_pwm.sv
// Purpose: Dual-slope and fast PWM part of a 16-bit timer.
// Assumes: All inputs synchronous to clk_sys_i (200 MHz).
// Notes:   Channel 0 is A, channel 1 is B.
`timescale 1ns/1ps
`default_nettype none
module timer16_dual_slope_pwm (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Register port
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rd_data_o,
    // Compare pins
    output logic      [1:0]  wave_out_chan_o,
    output logic      [1:0]  wave_oe_chan_o
);
    ////////////////////////////////////////////////////////////
    logic [10:0]       ctrl;
    logic [15:0]       match_buf [2];
    logic [15:0]       match_act [2];
    logic [15:0]       capture_top_value;
    logic [15:0]       count_value;
    logic [3:0]        flags;
    logic [1:0]        pin_direction_bit;
    logic [1:0]        wave;
    logic [9:0]        pre_cnt;
    pwm16_pkg::dir_t   dir;
    logic [3:0]        waveform_mode_select;
    logic [1:0]        output_mode_chan [2];
    logic [2:0]        clk_sel;
    logic              tick;
    logic              mode_pc;
    logic              mode_pfc;
    logic              mode_fast;
    logic              dual;
    logic              buffered;
    logic              top_cap;
    logic [15:0]       top;
    logic [15:0]       wmask;
    logic              at_top;
    logic              at_bot;
    logic              load_evt;
    logic              eff_up;
    logic              cnt_wr;
    logic [1:0]        hit;
    logic [3:0]        next_set;

    assign waveform_mode_select = ctrl[pwm16_pkg::CTRL_MODE_LSB +: 4];
    assign output_mode_chan[0]  = ctrl[pwm16_pkg::CTRL_COMA_LSB +: 2];
    assign output_mode_chan[1]  = ctrl[pwm16_pkg::CTRL_COMB_LSB +: 2];
    assign clk_sel              = ctrl[pwm16_pkg::CTRL_CSEL_LSB +: 3];

    ////////////////////////////////////////////////////////////
    // Mode decode and top selection.
    always_comb begin
        mode_pc   = 1'b0;
        mode_pfc  = 1'b0;
        mode_fast = 1'b0;
        top_cap   = 1'b0;
        top       = pwm16_pkg::MAXV;
        wmask     = pwm16_pkg::MAXV;
        case (waveform_mode_select)
            pwm16_pkg::MODE_PC8: begin
                mode_pc = 1'b1;
                top     = pwm16_pkg::TOP8;
                wmask   = pwm16_pkg::TOP8;
            end
            pwm16_pkg::MODE_PC9: begin
                mode_pc = 1'b1;
                top     = pwm16_pkg::TOP9;
                wmask   = pwm16_pkg::TOP9;
            end
            pwm16_pkg::MODE_PC10: begin
                mode_pc = 1'b1;
                top     = pwm16_pkg::TOP10;
                wmask   = pwm16_pkg::TOP10;
            end
            pwm16_pkg::MODE_PC_C: begin
                mode_pc = 1'b1;
                top_cap = 1'b1;
                top     = capture_top_value;
            end
            pwm16_pkg::MODE_PC_A: begin
                mode_pc = 1'b1;
                top     = match_act[0];
            end
            pwm16_pkg::MODE_PFC_C: begin
                mode_pfc = 1'b1;
                top_cap  = 1'b1;
                top      = capture_top_value;
            end
            pwm16_pkg::MODE_PFC_A: begin
                mode_pfc = 1'b1;
                top      = match_act[0];
            end
            pwm16_pkg::MODE_FST_C: begin
                mode_fast = 1'b1;
                top_cap   = 1'b1;
                top       = capture_top_value;
            end
            pwm16_pkg::MODE_FST_A: begin
                mode_fast = 1'b1;
                top       = match_act[0];
            end
            default: begin
                top = pwm16_pkg::MAXV;
            end
        endcase
    end

    assign dual     = mode_pc | mode_pfc;
    assign buffered = dual | mode_fast;
    assign at_top   = tick && (count_value == top);
    assign at_bot   = tick && dual && (count_value == 16'h0000);
    // Phase correct loads at top, the other dual mode at bottom.
    assign load_evt = (mode_pfc ? at_bot : at_top) && buffered;
    // Bottom counts as rising and top as falling, so the extreme match
    // values give a steady level instead of a one-tick glitch.
    assign eff_up   = (count_value == 16'h0000) ||
                      (dir == pwm16_pkg::DIR_UP && count_value != top);
    assign cnt_wr   = wr_i && (addr_i == pwm16_pkg::OFS_COUNT);
    assign hit[0]   = tick && (count_value == match_act[0]);
    assign hit[1]   = tick && (count_value == match_act[1]);

    ////////////////////////////////////////////////////////////
    // Prescaler, free running; a select of zero stops the timer.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt <= 10'h000;
        end else begin
            pre_cnt <= pre_cnt + 10'h001;
        end
    end

    always_comb begin
        case (clk_sel)
            3'h1:    tick = 1'b1;
            3'h2:    tick = (pre_cnt & pwm16_pkg::PRE_M8) == pwm16_pkg::PRE_M8;
            3'h3:    tick = (pre_cnt & pwm16_pkg::PRE_M64) == pwm16_pkg::PRE_M64;
            3'h4:    tick = (pre_cnt & pwm16_pkg::PRE_M256) == pwm16_pkg::PRE_M256;
            3'h5:    tick = pre_cnt == pwm16_pkg::PRE_M1024;
            default: tick = 1'b0;
        endcase
    end
    ////////////////////////////////////////////////////////////
    // Counter and direction.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_value <= 16'h0000;
            dir         <= pwm16_pkg::DIR_UP;
        end else if (cnt_wr) begin
            count_value <= wr_data_i;
        end else if (tick) begin
            if (dual) begin
                case (dir)
                    pwm16_pkg::DIR_UP: begin
                        if (count_value == top) begin
                            dir         <= pwm16_pkg::DIR_DOWN;
                            count_value <= count_value - 16'h0001;
                        end else begin
                            count_value <= count_value + 16'h0001;
                        end
                    end
                    pwm16_pkg::DIR_DOWN: begin
                        if (count_value == 16'h0000) begin
                            dir         <= pwm16_pkg::DIR_UP;
                            count_value <= 16'h0001;
                        end else begin
                            count_value <= count_value - 16'h0001;
                        end
                    end
                    default: begin
                        dir <= pwm16_pkg::DIR_UP;
                    end
                endcase
            end else if (mode_fast && count_value == top) begin
                count_value <= 16'h0000;
                dir         <= pwm16_pkg::DIR_UP;
            end else begin
                count_value <= count_value + 16'h0001;
                dir         <= pwm16_pkg::DIR_UP;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Control, capture top and pin direction registers.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl              <= 11'h000;
            capture_top_value <= 16'h0000;
            pin_direction_bit <= 2'h0;
        end else if (wr_i) begin
            case (addr_i)
                pwm16_pkg::OFS_CTRL:   ctrl <= wr_data_i[10:0];
                pwm16_pkg::OFS_CAPTOP: capture_top_value <= wr_data_i;
                pwm16_pkg::OFS_DIR:    pin_direction_bit <= wr_data_i[1:0];
                default:               ctrl <= ctrl;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Match buffers; without a PWM mode the active value follows
    // the write at once, which can skip a match mid-period.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 2; i++) begin
                match_buf[i] <= 16'h0000;
                match_act[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_i && addr_i == (pwm16_pkg::OFS_MATCH_A + 3'(i))) begin
                    match_buf[i] <= wr_data_i & wmask;
                    if (!buffered) begin
                        match_act[i] <= wr_data_i & wmask;
                    end
                end
                if (load_evt) begin
                    match_act[i] <= match_buf[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Flags; a set in the same cycle as a clear wins.
    always_comb begin
        next_set          = 4'h0;
        next_set[pwm16_pkg::FLG_OVF] = mode_pc ? at_bot :
                                       mode_pfc ? at_bot :
                                       at_top;
        next_set[pwm16_pkg::FLG_MA]  = hit[0];
        next_set[pwm16_pkg::FLG_MB]  = hit[1];
        next_set[pwm16_pkg::FLG_CAP] = at_top && top_cap;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags <= 4'h0;
        end else if (wr_i && addr_i == pwm16_pkg::OFS_FLAGS) begin
            flags <= (flags & ~wr_data_i[3:0]) | next_set;
        end else begin
            flags <= flags | next_set;
        end
    end

    ////////////////////////////////////////////////////////////
    // Waveform generation per channel.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wave <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (dual && hit[i]) begin
                    case (output_mode_chan[i])
                        pwm16_pkg::COM_NINV: wave[i] <= ~eff_up;
                        pwm16_pkg::COM_INV:  wave[i] <= eff_up;
                        pwm16_pkg::COM_TOG: begin
                            if (i == 0 && (waveform_mode_select == pwm16_pkg::MODE_PC_A ||
                                           waveform_mode_select == pwm16_pkg::MODE_PFC_A)) begin
                                wave[i] <= ~wave[i];
                            end
                        end
                        default: wave[i] <= wave[i];
                    endcase
                end else if (mode_fast) begin
                    case (output_mode_chan[i])
                        pwm16_pkg::COM_TOG: begin
                            if (i == 0 && hit[i]) begin
                                wave[i] <= ~wave[i];
                            end
                        end
                        pwm16_pkg::COM_NINV: begin
                            if (at_top) begin
                                wave[i] <= 1'b1;
                            end else if (hit[i]) begin
                                wave[i] <= 1'b0;
                            end
                        end
                        pwm16_pkg::COM_INV: begin
                            if (at_top) begin
                                wave[i] <= 1'b0;
                            end else if (hit[i]) begin
                                wave[i] <= 1'b1;
                            end
                        end
                        default: wave[i] <= wave[i];
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Pins and read data.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wave_out_chan_o <= 2'h0;
            wave_oe_chan_o  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                wave_out_chan_o[i] <= wave[i] && pin_direction_bit[i] &&
                                      output_mode_chan[i] != pwm16_pkg::COM_OFF;
                wave_oe_chan_o[i]  <= pin_direction_bit[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                pwm16_pkg::OFS_CTRL:    rd_data_o <= {5'h00, ctrl};
                pwm16_pkg::OFS_MATCH_A: rd_data_o <= match_buf[0];
                pwm16_pkg::OFS_MATCH_B: rd_data_o <= match_buf[1];
                pwm16_pkg::OFS_CAPTOP:  rd_data_o <= capture_top_value;
                pwm16_pkg::OFS_COUNT:   rd_data_o <= count_value;
                pwm16_pkg::OFS_FLAGS:   rd_data_o <= {12'h000, flags};
                pwm16_pkg::OFS_DIR:     rd_data_o <= {14'h0000, pin_direction_bit};
                default:                rd_data_o <= 16'h0000;
            endcase
        end else begin
            rd_data_o <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////
    // Checks.
    AST_FAST_TOGGLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (mode_fast && output_mode_chan[0] == pwm16_pkg::COM_TOG && hit[0])
        |=> (wave[0] != $past(wave[0])))
        else $error("Fast toggle did not flip output A.");
    AST_MAX_FREQ: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (tick && waveform_mode_select == pwm16_pkg::MODE_FST_A && match_act[0] == 16'h0000
         && count_value == 16'h0000 && !cnt_wr) |=> (count_value == 16'h0000))
        else $error("Zero top did not hold the count at zero.");
    AST_FAST_BUF: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (mode_fast && !load_evt) |=> $stable(match_act[0]))
        else $error("Match A changed outside a load in fast mode.");
    AST_TOP_REVERSE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (tick && dual && dir == pwm16_pkg::DIR_UP && count_value == top && !cnt_wr)
        |=> (dir == pwm16_pkg::DIR_DOWN && count_value == $past(count_value) - 16'h0001))
        else $error("Count did not reverse after top.");
    AST_OVF_BOTTOM: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (tick && mode_pc && count_value == 16'h0000) |=> flags[pwm16_pkg::FLG_OVF])
        else $error("Overflow flag missing at bottom.");
    AST_LOAD_TOP: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (mode_pc && at_top) |=> (match_act[1] == $past(match_buf[1])))
        else $error("Buffer not loaded at top.");
    AST_LOAD_BOT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (mode_pfc && at_bot) |=> (match_act[1] == $past(match_buf[1]) && flags[pwm16_pkg::FLG_OVF]))
        else $error("Buffer or overflow missing at bottom.");
    AST_MASK: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (wr_i && addr_i == pwm16_pkg::OFS_MATCH_B && waveform_mode_select == pwm16_pkg::MODE_PC8)
        |=> (match_buf[1][15:8] == 8'h00))
        else $error("Write not masked to fixed resolution.");
    AST_MATCH_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (tick && count_value == match_act[1]) |=> flags[pwm16_pkg::FLG_MB])
        else $error("Match flag B not set.");
    AST_PIN_DIR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (!pin_direction_bit[0]) |=> (!wave_out_chan_o[0] && !wave_oe_chan_o[0]))
        else $error("Pin A driven while set as input.");
    AST_NO_TICK: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (!tick && !cnt_wr) |=> $stable(count_value))
        else $error("Count moved without a tick.");
endmodule // timer16_dual_slope_pwm
`default_nettype wire

// >>> core/pwm16_pkg.sv
// Purpose: Constants shared by the dual-slope PWM timer.
// Assumes: 16-bit count, register port with 3-bit word address.
// Notes:   Offsets and field positions are local to this block.
package pwm16_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int ADDR_W        = 3;
    localparam int DATA_W        = 16;
    // Register word addresses.
    localparam logic [2:0] OFS_CTRL    = 3'h0;
    localparam logic [2:0] OFS_MATCH_A = 3'h1;
    localparam logic [2:0] OFS_MATCH_B = 3'h2;
    localparam logic [2:0] OFS_CAPTOP  = 3'h3;
    localparam logic [2:0] OFS_COUNT   = 3'h4;
    localparam logic [2:0] OFS_FLAGS   = 3'h5;
    localparam logic [2:0] OFS_DIR     = 3'h6;
    // Control field positions.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_COMA_LSB = 4;
    localparam int CTRL_COMB_LSB = 6;
    localparam int CTRL_CSEL_LSB = 8;
    localparam int CTRL_W        = 11;
    // Flag bit positions.
    localparam int FLG_OVF = 0;
    localparam int FLG_MA  = 1;
    localparam int FLG_MB  = 2;
    localparam int FLG_CAP = 3;
    // Waveform modes.
    localparam logic [3:0] MODE_PC8   = 4'h1;
    localparam logic [3:0] MODE_PC9   = 4'h2;
    localparam logic [3:0] MODE_PC10  = 4'h3;
    localparam logic [3:0] MODE_PFC_C = 4'h8;
    localparam logic [3:0] MODE_PFC_A = 4'h9;
    localparam logic [3:0] MODE_PC_C  = 4'ha;
    localparam logic [3:0] MODE_PC_A  = 4'hb;
    localparam logic [3:0] MODE_FST_C = 4'he;
    localparam logic [3:0] MODE_FST_A = 4'hf;
    // Fixed tops and masks.
    localparam logic [15:0] TOP8  = 16'h00ff;
    localparam logic [15:0] TOP9  = 16'h01ff;
    localparam logic [15:0] TOP10 = 16'h03ff;
    localparam logic [15:0] MAXV  = 16'hffff;
    // Output modes.
    localparam logic [1:0] COM_OFF  = 2'h0;
    localparam logic [1:0] COM_TOG  = 2'h1;
    localparam logic [1:0] COM_NINV = 2'h2;
    localparam logic [1:0] COM_INV  = 2'h3;
    // Prescaler masks for factors 8, 64, 256, 1024.
    localparam logic [9:0] PRE_M8    = 10'h007;
    localparam logic [9:0] PRE_M64   = 10'h03f;
    localparam logic [9:0] PRE_M256  = 10'h0ff;
    localparam logic [9:0] PRE_M1024 = 10'h3ff;
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;
endpackage

// >>> verification/timer16_dual_slope_pwm_tb_top.sv
// Purpose: Self-checking bench for the dual-slope PWM timer.
// Assumes: Register port with one-cycle strobes, read data one cycle later.
// Notes:   Counts, flags and pin waveforms are checked against figures worked out here.
`timescale 1ns/1ps
`default_nettype none
module timer16_dual_slope_pwm_tb_top;
    logic        clk_sys_i;
    logic        rst_b_i;
    logic [2:0]  addr_i;
    logic [15:0] wr_data_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rd_data_o;
    logic [1:0]  wave_out_chan_o;
    logic [1:0]  wave_oe_chan_o;
    int          err_count;
    int          checked;
    logic [15:0] rv;
    logic [15:0] tp;
    logic        cap;

    timer16_dual_slope_pwm u_dut (
        .clk_sys_i       (clk_sys_i),
        .rst_b_i         (rst_b_i),
        .addr_i          (addr_i),
        .wr_data_i       (wr_data_i),
        .wr_i            (wr_i),
        .rd_i            (rd_i),
        .rd_data_o       (rd_data_o),
        .wave_out_chan_o (wave_out_chan_o),
        .wave_oe_chan_o  (wave_oe_chan_o)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #(pwm16_pkg::CLK_PERIOD_NS / 2.0) clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        wr_i      <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d = rd_data_o;
    endtask

    // Stops the timer first so that match writes land directly, not in the buffer.
    task automatic setup(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb,
                         input logic [15:0] ma, input logic [15:0] mb, input logic [15:0] ct,
                         input logic [2:0] cs);
        wr(pwm16_pkg::OFS_CTRL, 16'h0000);
        wr(pwm16_pkg::OFS_COUNT, 16'h0000);
        wr(pwm16_pkg::OFS_MATCH_A, ma);
        wr(pwm16_pkg::OFS_MATCH_B, mb);
        wr(pwm16_pkg::OFS_CAPTOP, ct);
        wr(pwm16_pkg::OFS_DIR, 16'h0003);
        wr(pwm16_pkg::OFS_CTRL, {5'h00, cs, cb, ca, m});
    endtask

    // Reads the count every cycle; each step must be one, never above top, top seen.
    task automatic walk(input logic [15:0] top);
        logic [15:0] prev;
        logic [15:0] cur;
        logic        hit;
        hit = 1'b0;
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= pwm16_pkg::OFS_COUNT;
        @(posedge clk_sys_i);
        #1 prev = rd_data_o;
        repeat (3 * top) begin
            @(posedge clk_sys_i);
            #1 cur = rd_data_o;
            chk(((cur > prev) ? cur - prev : prev - cur) | ((cur > top) ? 16'h8000 : 16'h0000),
                16'h0001);
            hit = hit | (cur == top);
            prev = cur;
        end
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        chk({15'h0000, hit}, 16'h0001);
    endtask

    task automatic wait_pin(input int b, input logic lv, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk_sys_i);
            #1 cyc++;
        end while (wave_out_chan_o[b] !== lv && cyc < 30000);
    endtask

    task automatic meas(input int b, input int hi, input int per);
        int h;
        int l;
        // Sync on a low level first, so a pin left high by the last test is not timed mid-pulse.
        wait_pin(b, 1'b0, h);
        wait_pin(b, 1'b1, h);
        wait_pin(b, 1'b0, h);
        wait_pin(b, 1'b1, l);
        chk(16'(h), 16'(hi));
        chk(16'(h + l), 16'(per));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        err_count++;
        results();
    end

    initial begin
        logic [3:0]  md [5];
        logic [15:0] tops [5];
        int          nf [5];
        md   = '{pwm16_pkg::MODE_PC_A, pwm16_pkg::MODE_PC_C, pwm16_pkg::MODE_PFC_A,
                 pwm16_pkg::MODE_PFC_C, pwm16_pkg::MODE_PC8};
        tops = '{16'h0005, 16'h0006, 16'h0005, 16'h0006, pwm16_pkg::TOP8};
        nf   = '{1, 8, 64, 256, 1024};
        err_count = 0;
        checked   = 0;
        rst_b_i   = 1'b0;
        addr_i    = 3'h0;
        wr_data_i = 16'h0000;
        wr_i      = 1'b0;
        rd_i      = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rd(pwm16_pkg::OFS_CTRL, rv);
        chk(rv, 16'h0000);
        wr(3'h7, 16'hffff);
        rd(3'h7, rv);
        chk(rv, 16'h0000);
        // Fixed tops mask the written match value to their width.
        for (int i = 0; i < 3; i++) begin
            wr(pwm16_pkg::OFS_CTRL, {12'h000, 4'(i + 1)});
            wr(pwm16_pkg::OFS_MATCH_B, 16'hffff);
            rd(pwm16_pkg::OFS_MATCH_B, rv);
            chk(rv, (i == 0) ? pwm16_pkg::TOP8 : (i == 1) ? pwm16_pkg::TOP9 : pwm16_pkg::TOP10);
        end
        // Dual-slope walk and flags for each top source.
        for (int i = 0; i < 5; i++) begin
            tp  = tops[i];
            cap = (md[i] == pwm16_pkg::MODE_PC_C) || (md[i] == pwm16_pkg::MODE_PFC_C);
            setup(md[i], pwm16_pkg::COM_OFF, pwm16_pkg::COM_OFF, cap ? 16'h0002 : tp,
                  16'h0001, cap ? tp : 16'h0000, 3'h1);
            walk(tp);
            wr(pwm16_pkg::OFS_FLAGS, 16'h000f);
            repeat (2 * tp + 4) @(posedge clk_sys_i);
            rd(pwm16_pkg::OFS_FLAGS, rv);
            chk(rv & 16'h000b, cap ? 16'h000b : 16'h0003);
        end
        // Period and duty at every prescale factor.
        for (int i = 0; i < 5; i++) begin
            setup(pwm16_pkg::MODE_PC_A, pwm16_pkg::COM_OFF, pwm16_pkg::COM_NINV, 16'h0005, 16'h0002,
                  16'h0000, 3'(i + 1));
            meas(1, 4 * nf[i], 10 * nf[i]);
        end
        setup(pwm16_pkg::MODE_PFC_A, pwm16_pkg::COM_OFF, pwm16_pkg::COM_INV, 16'h0005, 16'h0002, 16'h0000, 3'h1);
        meas(1, 6, 10);
        setup(pwm16_pkg::MODE_PC_A, pwm16_pkg::COM_TOG, pwm16_pkg::COM_OFF, 16'h0005, 16'h0000, 16'h0000, 3'h1);
        meas(0, 10, 20);
        setup(pwm16_pkg::MODE_FST_A, pwm16_pkg::COM_TOG, pwm16_pkg::COM_OFF, 16'h0003, 16'h0000, 16'h0000, 3'h1);
        meas(0, 4, 8);
        // A new top written while running lands through the buffer at the next top.
        wr(pwm16_pkg::OFS_MATCH_A, 16'h0007);
        meas(0, 8, 16);
        setup(pwm16_pkg::MODE_FST_A, pwm16_pkg::COM_TOG, pwm16_pkg::COM_OFF, 16'h0000, 16'h0000, 16'h0000, 3'h1);
        repeat (4) @(posedge clk_sys_i);
        #1 rv = {15'h0000, wave_out_chan_o[0]};
        repeat (8) begin
            @(posedge clk_sys_i);
            #1 chk({15'h0000, wave_out_chan_o[0]}, ~rv & 16'h0001);
            rv = {15'h0000, wave_out_chan_o[0]};
        end
        // Match at bottom or top pins the level; the last case leaves pin B high.
        for (int i = 0; i < 4; i++) begin
            setup(pwm16_pkg::MODE_PC_A, pwm16_pkg::COM_OFF, i[1] ? pwm16_pkg::COM_NINV : pwm16_pkg::COM_INV,
                  16'h0005, i[0] ? 16'h0005 : 16'h0000, 16'h0000, 3'h1);
            repeat (14) @(posedge clk_sys_i);
            repeat (12) begin
                @(posedge clk_sys_i);
                #1 chk({15'h0000, wave_out_chan_o[1]}, {15'h0000, i[0] ~^ i[1]});
            end
        end
        chk({14'h0, wave_oe_chan_o}, 16'h0003);
        wr(pwm16_pkg::OFS_DIR, 16'h0000);
        repeat (3) @(posedge clk_sys_i);
        #1 chk({12'h000, wave_oe_chan_o, wave_out_chan_o}, 16'h0000);
        // A stopped prescaler freezes the count.
        wr(pwm16_pkg::OFS_CTRL, {12'h000, pwm16_pkg::MODE_PC_A});
        wr(pwm16_pkg::OFS_COUNT, 16'h0003);
        repeat (20) @(posedge clk_sys_i);
        rd(pwm16_pkg::OFS_COUNT, rv);
        chk(rv, 16'h0003);
        results();
    end
endmodule // timer16_dual_slope_pwm_tb_top
`default_nettype wire
